// *** hdl/abu_top.v ***
// Purpose: Address breakpoint unit with APB register access and interrupt.
// Assumes: Core signals are synchronous to clk; sys_rst is synchronous.
// Notes: The core performs instruction completion timing and vector fetch.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "abu_regs.vh"
module abu_top (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire [15:0] cpu_addr,
  input  wire        cpu_addr_from_pc,
  input  wire        cpu_instr_last_cycle,
  input  wire        cpu_break_ack,
  input  wire        cpu_in_wait,
  input  wire        cpu_in_stop,
  input  wire        monitor_mode,
  output reg         break_req_reg,
  output wire        load_swi,
  output wire [15:0] break_vector,
  output wire        wake_from_stop,
  output reg         in_break_reg,
  output wire        status_clear_allow,
  output wire        irq
);
  reg  [7:0] addr_high_reg;
  reg  [7:0] addr_low_reg;
  reg        enable_reg;
  reg        active_reg;
  reg        wait_flag_reg;
  reg        stop_wait_reg;
  reg        clear_enable_reg;
  reg  [`ABU_IRQ_WIDTH-1:0] irq_status_reg;
  reg  [`ABU_IRQ_WIDTH-1:0] irq_mask_reg;
  reg  [31:0] read_word;
  wire       match;
  wire       wr;
  wire       rd;
  wire       soft_trigger;
  wire       trigger;
  wire       ack_wait;
  wire       ack_stop;
  wire [`ABU_IRQ_WIDTH-1:0] irq_events;
  wire       hit_control;
  wire       hit_addr_high;
  wire       hit_addr_low;
  wire       hit_wait_status;
  wire       hit_flag_clear;
  wire       hit_irq_status;
  wire       hit_irq_mask;
  wire       wr_control;
  wire       wr_addr_high;
  wire       wr_addr_low;
  wire       wr_wait_status;
  wire       wr_flag_clear;
  wire       wr_irq_status;
  wire       wr_irq_mask;
  wire       active_next;
  wire       wait_flag_next;
  wire       stop_wait_next;
  wire       break_req_next;
  wire       in_break_next;
  wire [`ABU_IRQ_WIDTH-1:0] irq_status_next;

  function sel;
    input [11:0] a;
    input [11:0] ofs;
    begin
      sel = (a[`ABU_ADDR_MSB:2] == ofs[`ABU_ADDR_MSB:2]);
    end
  endfunction

  // Sticky bit update: a hardware set in the same cycle as a clear wins.
  function set_clear;
    input cur;
    input set;
    input clr;
    begin
      if (set) begin
        set_clear = 1'b1;
      end else if (clr) begin
        set_clear = 1'b0;
      end else begin
        set_clear = cur;
      end
    end
  endfunction

  abu_comparator u_cmp (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .cpu_addr         (cpu_addr),
    .cpu_addr_from_pc (cpu_addr_from_pc),
    .bp_addr          ({addr_high_reg, addr_low_reg}),
    .enable           (enable_reg),
    .match_reg        (match)
  );

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr = psel & penable & pwrite;
  // Read data are fetched in the setup cycle, so the access cycle needs no wait state.
  assign rd = psel & ~penable & ~pwrite;

  assign hit_control     = sel(paddr, `ABU_OFS_STATUS_CONTROL);
  assign hit_addr_high   = sel(paddr, `ABU_OFS_ADDR_HIGH);
  assign hit_addr_low    = sel(paddr, `ABU_OFS_ADDR_LOW);
  assign hit_wait_status = sel(paddr, `ABU_OFS_WAIT_STATUS);
  assign hit_flag_clear  = sel(paddr, `ABU_OFS_FLAG_CLEAR);
  assign hit_irq_status  = sel(paddr, `ABU_OFS_IRQ_STATUS);
  assign hit_irq_mask    = sel(paddr, `ABU_OFS_IRQ_MASK);

  assign wr_control     = wr & hit_control;
  assign wr_addr_high   = wr & hit_addr_high;
  assign wr_addr_low    = wr & hit_addr_low;
  assign wr_wait_status = wr & hit_wait_status;
  assign wr_flag_clear  = wr & hit_flag_clear;
  assign wr_irq_status  = wr & hit_irq_status;
  assign wr_irq_mask    = wr & hit_irq_mask;

  assign soft_trigger = wr_control & pwdata[`ABU_BIT_ACTIVE];
  assign trigger = match | soft_trigger;
  assign ack_wait = cpu_break_ack & cpu_in_wait;
  assign ack_stop = cpu_break_ack & cpu_in_stop;
  assign irq_events = {ack_wait, soft_trigger, match};
  assign irq = |(irq_status_reg & irq_mask_reg);

  // The core waits for the last cycle of its instruction before it takes the request.
  assign load_swi = break_req_reg & cpu_instr_last_cycle;
  assign break_vector = monitor_mode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL;
  assign wake_from_stop = break_req_reg & cpu_in_stop;
  assign status_clear_allow = ~in_break_reg | clear_enable_reg;

  // A match in the same cycle as a clearing write wins, so no break is lost.
  assign active_next    = set_clear(active_reg, trigger, wr_control);
  assign wait_flag_next = set_clear(wait_flag_reg, ack_wait,
                                    wr_wait_status & ~pwdata[`ABU_BIT_WAIT]);
  assign stop_wait_next = set_clear(stop_wait_reg, ack_stop,
                                    wr_wait_status & ~pwdata[`ABU_BIT_STOP_WAIT]);
  assign break_req_next = set_clear(break_req_reg, trigger, cpu_break_ack);
  // The break state ends only once software has cleared the active flag.
  assign in_break_next  = set_clear(in_break_reg, cpu_break_ack, ~active_reg);
  assign irq_status_next = (wr_irq_status ? (irq_status_reg & ~pwdata[`ABU_IRQ_WIDTH-1:0]) : irq_status_reg)
                           | irq_events;

  always @(posedge clk) begin
    if (sys_rst) begin
      addr_high_reg <= `ABU_RESET_BYTE;
    end else if (wr_addr_high) begin
      addr_high_reg <= pwdata[7:0];
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      addr_low_reg <= `ABU_RESET_BYTE;
    end else if (wr_addr_low) begin
      addr_low_reg <= pwdata[7:0];
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      enable_reg <= 1'b0;
    end else if (wr_control) begin
      enable_reg <= pwdata[`ABU_BIT_ENABLE];
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      wait_flag_reg <= 1'b0;
    end else begin
      wait_flag_reg <= wait_flag_next;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      stop_wait_reg <= 1'b0;
    end else begin
      stop_wait_reg <= stop_wait_next;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      clear_enable_reg <= 1'b0;
    end else if (wr_flag_clear) begin
      clear_enable_reg <= pwdata[`ABU_BIT_CLEAR_ENABLE];
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      break_req_reg <= 1'b0;
    end else begin
      break_req_reg <= break_req_next;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      in_break_reg <= 1'b0;
    end else begin
      in_break_reg <= in_break_next;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      irq_mask_reg <= `ABU_RESET_IRQ;
    end else if (wr_irq_mask) begin
      irq_mask_reg <= pwdata[`ABU_IRQ_WIDTH-1:0];
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      irq_status_reg <= `ABU_RESET_IRQ;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // Unmapped offsets read as zero and never raise an error.
  always @* begin
    read_word = `ABU_READ_ZERO;
    if (hit_control) begin
      read_word[`ABU_BIT_ENABLE] = enable_reg;
      read_word[`ABU_BIT_ACTIVE] = active_reg;
    end else if (hit_addr_high) begin
      read_word[7:0] = addr_high_reg;
    end else if (hit_addr_low) begin
      read_word[7:0] = addr_low_reg;
    end else if (hit_wait_status) begin
      read_word[`ABU_BIT_WAIT]      = wait_flag_reg;
      read_word[`ABU_BIT_STOP_WAIT] = stop_wait_reg;
    end else if (hit_flag_clear) begin
      read_word[`ABU_BIT_CLEAR_ENABLE] = clear_enable_reg;
    end else if (hit_irq_status) begin
      read_word[`ABU_IRQ_WIDTH-1:0] = irq_status_reg;
    end else if (hit_irq_mask) begin
      read_word[`ABU_IRQ_WIDTH-1:0] = irq_mask_reg;
    end else begin
      read_word = `ABU_READ_ZERO;
    end
  end

  // Read data stand from the access cycle until the next read setup.
  always @(posedge clk) begin
    if (sys_rst) begin
      prdata <= `ABU_READ_ZERO;
    end else if (rd) begin
      prdata <= read_word;
    end
  end
endmodule

// *** common/abu_regs.vh ***
// Purpose: Register map and field positions of the address breakpoint unit.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
`ifndef ABU_REGS_VH
`define ABU_REGS_VH
`define ABU_OFS_STATUS_CONTROL 12'h000
`define ABU_OFS_ADDR_HIGH      12'h004
`define ABU_OFS_ADDR_LOW       12'h008
`define ABU_OFS_WAIT_STATUS    12'h00c
`define ABU_OFS_FLAG_CLEAR     12'h010
`define ABU_OFS_IRQ_STATUS     12'h014
`define ABU_OFS_IRQ_MASK       12'h018
`define ABU_BIT_ENABLE         7
`define ABU_BIT_ACTIVE         6
`define ABU_BIT_WAIT           1
`define ABU_BIT_STOP_WAIT      0
`define ABU_BIT_CLEAR_ENABLE   7
`define ABU_IRQ_BIT_MATCH      0
`define ABU_IRQ_BIT_SOFT       1
`define ABU_IRQ_BIT_WAKE       2
`define ABU_IRQ_WIDTH          3
`define ABU_RESET_BYTE         8'h00
`define ABU_RESET_IRQ          3'h0
`define ABU_VEC_NORMAL         16'hfffc
`define ABU_VEC_MONITOR        16'hfefc
`define ABU_ADDR_MSB           11
`define ABU_READ_ZERO          32'h00000000
`endif

// *** hdl/abu_comparator.v ***
// Purpose: Compares the program address with the breakpoint address.
// Assumes: All inputs are on clk.
// Notes: Registered output adds one cycle of latency.
`timescale 1ns/1ps
module abu_comparator (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [15:0] cpu_addr,
  input  wire        cpu_addr_from_pc,
  input  wire [15:0] bp_addr,
  input  wire        enable,
  output reg         match_reg
);
  always @(posedge clk) begin
    if (sys_rst) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= enable & cpu_addr_from_pc & (cpu_addr == bp_addr);
    end
  end
endmodule

// *** tb/abu_monitor.sv ***
// Purpose: Port checker of the breakpoint unit.
// Assumes: One clock, synchronous reset high.
// Notes: Bound into abu_top at the foot.
`timescale 1ns/1ps
module abu_chk (
  input        clk,
  input        sys_rst,
  input        psel,
  input        penable,
  input        pwrite,
  input [11:0] paddr,
  input [31:0] pwdata,
  input        cpu_addr_from_pc,
  input        cpu_instr_last_cycle,
  input        cpu_break_ack,
  input        cpu_in_stop,
  input        break_req_reg,
  input        load_swi,
  input        wake_from_stop,
  input        in_break_reg,
  input        status_clear_allow
);
  wire wr = psel && penable && pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_hold; break_req_reg && !cpu_break_ack |=> break_req_reg; endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_ack; cpu_break_ack && !wr |=> !break_req_reg; endproperty
  a_ack: assert property (p_ack) else $error("request kept after ack");
  property p_swi; load_swi == (break_req_reg && cpu_instr_last_cycle); endproperty
  a_swi: assert property (p_swi) else $error("swi load wrong");
  property p_stop; wake_from_stop == (break_req_reg && cpu_in_stop); endproperty
  a_stop: assert property (p_stop) else $error("stop wake wrong");
  // The match path is two registers deep, so the cause lies two samples back.
  property p_pc; $rose(break_req_reg) |-> $past(cpu_addr_from_pc, 2) || $past(wr); endproperty
  a_pc: assert property (p_pc) else $error("break without cause");
  property p_soft; wr && paddr == 12'h000 && pwdata[6] |=> break_req_reg; endproperty
  a_soft: assert property (p_soft) else $error("soft break missing");
  property p_cfe; !in_break_reg |-> status_clear_allow; endproperty
  a_cfe: assert property (p_cfe) else $error("clear blocked outside break");
  property p_rst; disable iff (1'b0) sys_rst |=> !break_req_reg && !in_break_reg; endproperty
  a_rst: assert property (p_rst) else $error("reset left break");
endmodule
bind abu_top abu_chk abu_chk_inst (.*);

// *** tb/abu_core.sv ***
// Purpose: Processor core model at the break interface.
// Assumes: Instructions last three cycles.
// Notes: Acks only while ack_en is high, to show a held request.
`timescale 1ns/1ps
module abu_core (
  input               clk,
  input               sys_rst,
  input               break_req_reg,
  input        [15:0] addr_in,
  input               pc_src,
  input               ack_en,
  output logic [15:0] cpu_addr,
  output logic        cpu_addr_from_pc,
  output logic        cpu_instr_last_cycle,
  output logic        cpu_break_ack
);
  logic [1:0] cnt;
  initial {cnt, cpu_addr, cpu_addr_from_pc, cpu_instr_last_cycle, cpu_break_ack} = '0;
  always @(posedge clk) begin
    cnt <= (sys_rst || cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
    cpu_instr_last_cycle <= cnt == 2'h1;
    {cpu_addr, cpu_addr_from_pc} <= {addr_in, pc_src};
    cpu_break_ack <= ack_en && break_req_reg && cpu_instr_last_cycle && !cpu_break_ack;
  end
endmodule

// *** tb/abu_top_tb.sv ***
// Purpose: Self-checking bench of the breakpoint unit.
// Assumes: Zero-wait APB, core model abu_core.
// Notes: Expected register values are kept in st, ws and ist.
`timescale 1ns/1ps
module abu_top_tb;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, cpu_in_wait = 0, cpu_in_stop = 0;
  logic monitor_mode = 0, pc_src = 0, ack_en = 0, pready, pslverr, cpu_addr_from_pc, cpu_instr_last_cycle;
  logic cpu_break_ack, break_req_reg, load_swi, wake_from_stop, in_break_reg, status_clear_allow, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic [15:0] cpu_addr, break_vector, bp, addr_in = 16'h0;
  int fails, total_checks, st, ws, ist;
  always #12.5 clk = ~clk;
  abu_top abu_top_inst (.*);
  abu_core abu_core_inst (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  // Callers wait for the falling edge first, so the value is taken once it has settled.
  task sig(input string nm, input logic [31:0] seen, input logic [31:0] e);
    chk(nm, seen, e);
  endtask
  task stop_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #75000;
    fails++;
    stop_test;
  end
  initial begin
    r = lfsr(32'h80392771);
    bp = r[15:0];
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rdc("reset", 12'(i * 4), 32'h0);
    apb(1'b1, 12'h004, {r[31:8], bp[15:8]});
    apb(1'b1, 12'h008, {24'h0, bp[7:0]});
    apb(1'b1, 12'h01c, r);
    rdc("addr_high", 12'h004, {24'h0, bp[15:8]});
    rdc("addr_low", 12'h008, {24'h0, bp[7:0]});
    rdc("unmapped", 12'h01c, 32'h0);
    addr_in <= bp;
    apb(1'b1, 12'h018, 32'h7);
    apb(1'b1, 12'h000, 32'h80);
    repeat (6) @(posedge clk);
    @(negedge clk) sig("data address", break_req_reg, 1'b0);
    apb(1'b1, 12'h000, 32'h0);
    pc_src <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk) sig("disabled", break_req_reg, 1'b0);
    apb(1'b1, 12'h000, 32'h80);
    {st, ist} = {32'hc0, 32'h1};
    repeat (6) @(posedge clk);
    @(negedge clk) sig("match", break_req_reg, 1'b1);
    rdc("active", 12'h000, st);
    @(negedge clk) sig("irq", irq, 1'b1);
    @(posedge clk);
    {addr_in, pc_src, cpu_in_wait} <= {~bp, 2'b01};
    repeat (6) @(posedge clk);
    ack_en <= 1'b1;
    repeat (8) @(posedge clk);
    {ws, ist} = {32'h2, 32'h5};
    @(negedge clk) sig("acked", {break_req_reg, in_break_reg, status_clear_allow}, 3'b010);
    rdc("wait flag", 12'h00c, ws);
    apb(1'b1, 12'h010, 32'h80);
    @(negedge clk) sig("clear allow", status_clear_allow, 1'b1);
    apb(1'b1, 12'h00c, 32'h0);
    {ws, cpu_in_wait} <= 2'b00;
    rdc("wait clear", 12'h00c, 32'h0);
    rdc("irq status", 12'h014, ist);
    apb(1'b1, 12'h014, ist);
    @(negedge clk) sig("irq clear", irq, 1'b0);
    apb(1'b1, 12'h000, 32'h80);
    rdc("active clear", 12'h000, 32'h80);
    @(negedge clk) sig("left break", in_break_reg, 1'b0);
    apb(1'b1, 12'h018, 32'h0);
    {monitor_mode, cpu_in_stop} <= 2'b11;
    apb(1'b1, 12'h000, 32'hc0);
    @(negedge clk) sig("stop wake", {wake_from_stop, irq, break_vector}, {2'b10, 16'hfefc});
    repeat (8) @(posedge clk);
    rdc("stop flag", 12'h00c, 32'h1);
    rdc("soft", 12'h014, 32'h2);
    stop_test;
  end
endmodule
